// ==== shared/pms_consts.vh ====
// constants of the pump motor staging sequencer
// Operation
// - mode selects none, fixed-time rotation, fixed-quantity circulation or control, or a combination.
// - motor count is one to eight, resets to one, and bounds the motors in use.
// - terminals get codes 55 upward, one per counted motor, the rest unassigned.
// - in fixed-time rotation the running motor stops when its run minutes reach the setting.
// - after that stop the switch delay passes before the next motor starts.
// - run time is 0 to 65500 minutes and zero halts timing until a stop.
// - input code 60 disables all motors and 61 to 68 one each, letting it coast.
// - fixed-quantity circulation stages four motors at most.
// - stage-up frequency held for the stage delay gives switch delay, mains, switch delay, next motor.
// - falling demand stops the operating motor, waits the decrement delay, repeats to the last one.
// - switching is prepared once output frequency reaches the stage-up frequency, default 60.00 Hz.
// - output frequency under stage-down frequency for the decrement delay sheds motors one by one.
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

`define PMS_REG_CTRL       8'h00
`define PMS_REG_RUN_TIME   8'h04
`define PMS_REG_SW_DELAY   8'h08
`define PMS_REG_DEC_DELAY  8'h0C
`define PMS_REG_PID_DELAY  8'h10
`define PMS_REG_FREQ       8'h14
`define PMS_REG_DI_SEL_A   8'h18
`define PMS_REG_DI_SEL_B   8'h1C
`define PMS_REG_STATUS     8'h20
`define PMS_REG_TERM_A     8'h24
`define PMS_REG_TERM_B     8'h28

`define PMS_RST_MODE       3'h0
`define PMS_RST_COUNT      4'h1
`define PMS_RST_RUN_TIME   16'h0000
`define PMS_RST_SW_DELAY   16'h000A
`define PMS_RST_DEC_DELAY  16'h000A
`define PMS_RST_PID_DELAY  16'h0064
`define PMS_RST_UP_FREQ    16'h1770
`define PMS_RST_DN_FREQ    16'h0000

`define PMS_MODE_NONE      3'h0
`define PMS_MODE_TIME      3'h1
`define PMS_MODE_FQ_CIRC   3'h2
`define PMS_MODE_FQ_CTRL   3'h3
`define PMS_MODE_T_CIRC    3'h4
`define PMS_MODE_T_CTRL    3'h5

`define PMS_MAX_COUNT      4'h8
`define PMS_CIRC_LIMIT     4'h4
`define PMS_TERM_BASE      8'h37
`define PMS_DIS_ALL        8'h3C
`define PMS_DIS_FIRST      8'h3D
`define PMS_DIS_LAST       8'h44
`define PMS_MAX_RUN_MIN    16'hFFDC

`define PMS_TENTH_CYC      20000000
`define PMS_TENTHS_PER_MIN 600

`endif

// ==== logic/pms_timebase.v ====
// tenth-second and minute enable pulses
`timescale 1ns/1ps
module pms_timebase #(
   parameter TENTH_CYCLES    = 20000000,
   parameter TENTHS_PER_MIN  = 600
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        clear_i,
   output reg         tenth_o,
   output reg         minute_o
);
   reg [31:0] cyc_cnt;
   reg [15:0] tenth_cnt;

   always @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         cyc_cnt   <= 32'h00000000;
         tenth_cnt <= 16'h0000;
         tenth_o   <= 1'b0;
         minute_o  <= 1'b0;
      end else begin
         tenth_o  <= 1'b0;
         minute_o <= 1'b0;
         if (cyc_cnt >= TENTH_CYCLES - 1) begin
            cyc_cnt <= 32'h00000000;
            tenth_o <= 1'b1;
            if (tenth_cnt >= TENTHS_PER_MIN - 1) begin
               tenth_cnt <= 16'h0000;
               minute_o  <= 1'b1;
            end else begin
               tenth_cnt <= tenth_cnt + 16'h0001;
            end
         end else begin
            cyc_cnt <= cyc_cnt + 32'h00000001;
         end
      end
   end
endmodule // pms_timebase

// ==== logic/pms_outmap.v ====
// output terminal function code assignment
`timescale 1ns/1ps
`include "pms_consts.vh"
module pms_outmap (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [3:0]  count_i,
   output reg  [63:0] codes_o
);
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_term
         localparam [7:0] IDX = k;
         always @(posedge clk_i) begin
            if (rst_i) begin
               codes_o[8*k +: 8] <= 8'h00;
            end else if (k < count_i) begin
               codes_o[8*k +: 8] <= `PMS_TERM_BASE + IDX;
            end else begin
               codes_o[8*k +: 8] <= 8'h00;
            end
         end
      end
   endgenerate
endmodule // pms_outmap

// ==== logic/pms_sequencer.v ====
// pump motor staging sequencer with wishbone registers
`timescale 1ns/1ps
`include "pms_consts.vh"
module pms_sequencer #(
   parameter TENTH_CYCLES = `PMS_TENTH_CYC
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [15:0] out_freq_i,
   input  wire        stop_cmd_i,
   input  wire [5:0]  multifunction_input_i,
   output reg  [7:0]  drive_connect_o,
   output reg  [7:0]  mains_connect_o
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_RUN   = 3'h1;
   localparam ST_ROT   = 3'h2;
   localparam ST_UP1   = 3'h3;
   localparam ST_UP2   = 3'h4;

   // configuration registers
   reg [2:0]  circulation_mode_select;
   reg [3:0]  motor_count;
   reg        soft_stop;
   reg [15:0] per_motor_run_time;
   reg [15:0] switch_delay;
   reg [15:0] decrement_delay;
   reg [15:0] pid_stage_delay;
   reg [15:0] stage_up_frequency;
   reg [15:0] stage_down_frequency;
   reg [47:0] multifunction_input_select;

   // sequencing state
   reg [2:0]  state;
   reg [2:0]  cur;
   reg [7:0]  drive_mask;
   reg [7:0]  mains_mask;
   reg [15:0] run_min;
   reg [15:0] dly;
   reg [15:0] hold_up;
   reg [15:0] hold_dn;

   reg [5:0]  di_meta;
   reg [5:0]  di_sync;
   reg        stop_meta;
   reg        stop_sync;

   wire       tenth;
   wire       minute;
   wire [63:0] term_codes;

   reg [7:0]  dis_mask;
   reg [3:0]  limit;
   reg [3:0]  staged;
   reg [2:0]  last_on;
   reg        quantity;
   reg        timed;
   reg        active;
   integer    i;
   integer    j;

   function [7:0] dis_decode;
      input [7:0] code;
      begin
         if (code == `PMS_DIS_ALL) begin
            dis_decode = 8'hFF;
         end else if (code >= `PMS_DIS_FIRST && code <= `PMS_DIS_LAST) begin
            dis_decode = 8'h01 << (code - `PMS_DIS_FIRST);
         end else begin
            dis_decode = 8'h00;
         end
      end
   endfunction

   function [2:0] next_idx;
      input [2:0] idx;
      input [3:0] cnt;
      begin
         if ({1'b0, idx} + 4'h1 >= cnt) begin
            next_idx = 3'h0;
         end else begin
            next_idx = idx + 3'h1;
         end
      end
   endfunction

   pms_timebase #(
      .TENTH_CYCLES   (TENTH_CYCLES),
      .TENTHS_PER_MIN (`PMS_TENTHS_PER_MIN)
   ) u_timebase (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clear_i  (~active),
      .tenth_o  (tenth),
      .minute_o (minute)
   );

   pms_outmap u_outmap (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .count_i (motor_count),
      .codes_o (term_codes)
   );

   // pin synchronisers
   always @(posedge clk_i) begin
      if (rst_i) begin
         di_meta   <= 6'h00;
         di_sync   <= 6'h00;
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
      end else begin
         di_meta   <= multifunction_input_i;
         di_sync   <= di_meta;
         stop_meta <= stop_cmd_i;
         stop_sync <= stop_meta;
      end
   end

   // mode and limit decode
   always @* begin
      dis_mask = 8'h00;
      for (i = 0; i < 6; i = i + 1) begin
         if (di_sync[i]) begin
            dis_mask = dis_mask | dis_decode(multifunction_input_select[8*i +: 8]);
         end
      end
      timed    = (circulation_mode_select == `PMS_MODE_TIME) ||
                 (circulation_mode_select == `PMS_MODE_T_CIRC) ||
                 (circulation_mode_select == `PMS_MODE_T_CTRL);
      quantity = (circulation_mode_select >= `PMS_MODE_FQ_CIRC) &&
                 (circulation_mode_select <= `PMS_MODE_T_CTRL);
      if ((circulation_mode_select == `PMS_MODE_FQ_CIRC ||
           circulation_mode_select == `PMS_MODE_T_CIRC) &&
          motor_count > `PMS_CIRC_LIMIT) begin
         limit = `PMS_CIRC_LIMIT;
      end else begin
         limit = motor_count;
      end
      staged  = 4'h0;
      last_on = 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
         staged = staged + {3'h0, mains_mask[i]};
         if (mains_mask[i]) begin
            last_on = i[2:0];
         end
      end
      active = (circulation_mode_select != `PMS_MODE_NONE) &&
               (circulation_mode_select <= `PMS_MODE_T_CTRL) &&
               !soft_stop && !stop_sync;
   end

   // sequencer
   always @(posedge clk_i) begin
      if (rst_i || !active) begin
         state      <= ST_IDLE;
         cur        <= 3'h0;
         drive_mask <= 8'h00;
         mains_mask <= 8'h00;
         run_min    <= 16'h0000;
         dly        <= 16'h0000;
         hold_up    <= 16'h0000;
         hold_dn    <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               cur        <= 3'h0;
               drive_mask <= 8'h01;
               state      <= ST_RUN;
            end
            ST_RUN: begin
               if (minute && per_motor_run_time != 16'h0000) begin
                  run_min <= run_min + 16'h0001;
               end
               if (quantity && out_freq_i >= stage_up_frequency &&
                   staged + 4'h1 < limit) begin
                  if (tenth) begin
                     hold_up <= hold_up + 16'h0001;
                  end
               end else begin
                  hold_up <= 16'h0000;
               end
               if (quantity && out_freq_i < stage_down_frequency &&
                   mains_mask != 8'h00) begin
                  if (tenth) begin
                     hold_dn <= hold_dn + 16'h0001;
                  end
               end else begin
                  hold_dn <= 16'h0000;
               end
               if (timed && mains_mask == 8'h00 &&
                   per_motor_run_time != 16'h0000 &&
                   run_min >= per_motor_run_time) begin
                  drive_mask <= 8'h00;
                  run_min    <= 16'h0000;
                  dly        <= 16'h0000;
                  state      <= ST_ROT;
               end else if (quantity && out_freq_i >= stage_up_frequency &&
                            staged + 4'h1 < limit && hold_up >= pid_stage_delay) begin
                  hold_up <= 16'h0000;
                  dly     <= 16'h0000;
                  state   <= ST_UP1;
               end else if (quantity && out_freq_i < stage_down_frequency &&
                            mains_mask != 8'h00 && hold_dn >= decrement_delay) begin
                  mains_mask[last_on] <= 1'b0;
                  hold_dn <= 16'h0000;
               end
            end
            ST_ROT: begin
               if (tenth) begin
                  dly <= dly + 16'h0001;
               end
               if (dly >= switch_delay) begin
                  cur        <= next_idx(cur, motor_count);
                  drive_mask <= 8'h01 << next_idx(cur, motor_count);
                  state      <= ST_RUN;
               end
            end
            ST_UP1: begin
               if (tenth) begin
                  dly <= dly + 16'h0001;
               end
               if (dly >= switch_delay) begin
                  drive_mask       <= 8'h00;
                  mains_mask[cur]  <= 1'b1;
                  dly              <= 16'h0000;
                  state            <= ST_UP2;
               end
            end
            ST_UP2: begin
               if (tenth) begin
                  dly <= dly + 16'h0001;
               end
               if (dly >= switch_delay) begin
                  cur        <= next_idx(cur, motor_count);
                  drive_mask <= 8'h01 << next_idx(cur, motor_count);
                  run_min    <= 16'h0000;
                  state      <= ST_RUN;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // relay outputs, disabled motors released
   always @(posedge clk_i) begin
      if (rst_i) begin
         drive_connect_o <= 8'h00;
         mains_connect_o <= 8'h00;
      end else if (!active) begin
         drive_connect_o <= 8'h00;
         mains_connect_o <= 8'h00;
      end else begin
         drive_connect_o <= drive_mask & ~dis_mask;
         mains_connect_o <= mains_mask & ~dis_mask;
      end
   end

   // wishbone slave
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o                   <= 1'b0;
         wb_dat_o                   <= 32'h00000000;
         circulation_mode_select    <= `PMS_RST_MODE;
         motor_count                <= `PMS_RST_COUNT;
         soft_stop                  <= 1'b0;
         per_motor_run_time         <= `PMS_RST_RUN_TIME;
         switch_delay               <= `PMS_RST_SW_DELAY;
         decrement_delay            <= `PMS_RST_DEC_DELAY;
         pid_stage_delay            <= `PMS_RST_PID_DELAY;
         stage_up_frequency         <= `PMS_RST_UP_FREQ;
         stage_down_frequency       <= `PMS_RST_DN_FREQ;
         multifunction_input_select <= 48'h000000000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && wb_we_i) begin
            case (wb_adr_i)
               `PMS_REG_CTRL: begin
                  if (wb_sel_i[0]) begin
                     circulation_mode_select <= wb_dat_i[2:0];
                     if (wb_dat_i[7:4] >= 4'h1 && wb_dat_i[7:4] <= `PMS_MAX_COUNT) begin
                        motor_count <= wb_dat_i[7:4];
                     end
                  end
                  if (wb_sel_i[1]) begin
                     soft_stop <= wb_dat_i[8];
                  end
               end
               `PMS_REG_RUN_TIME: begin
                  if (wb_sel_i[0] && wb_sel_i[1]) begin
                     if (wb_dat_i[15:0] <= `PMS_MAX_RUN_MIN) begin
                        per_motor_run_time <= wb_dat_i[15:0];
                     end
                  end
               end
               `PMS_REG_SW_DELAY: begin
                  if (wb_sel_i[0] && wb_sel_i[1]) begin
                     switch_delay <= wb_dat_i[15:0];
                  end
               end
               `PMS_REG_DEC_DELAY: begin
                  if (wb_sel_i[0] && wb_sel_i[1]) begin
                     decrement_delay <= wb_dat_i[15:0];
                  end
               end
               `PMS_REG_PID_DELAY: begin
                  if (wb_sel_i[0] && wb_sel_i[1]) begin
                     pid_stage_delay <= wb_dat_i[15:0];
                  end
               end
               `PMS_REG_FREQ: begin
                  if (wb_sel_i[0] && wb_sel_i[1]) begin
                     stage_up_frequency <= wb_dat_i[15:0];
                  end
                  if (wb_sel_i[2] && wb_sel_i[3]) begin
                     stage_down_frequency <= wb_dat_i[31:16];
                  end
               end
               `PMS_REG_DI_SEL_A: begin
                  for (j = 0; j < 4; j = j + 1) begin
                     if (wb_sel_i[j]) begin
                        multifunction_input_select[8*j +: 8] <= wb_dat_i[8*j +: 8];
                     end
                  end
               end
               `PMS_REG_DI_SEL_B: begin
                  for (j = 0; j < 2; j = j + 1) begin
                     if (wb_sel_i[j]) begin
                        multifunction_input_select[32 + 8*j +: 8] <= wb_dat_i[8*j +: 8];
                     end
                  end
               end
               default: begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `PMS_REG_CTRL:      wb_dat_o <= {23'h000000, soft_stop, motor_count,
                                                1'b0, circulation_mode_select};
               `PMS_REG_RUN_TIME:  wb_dat_o <= {16'h0000, per_motor_run_time};
               `PMS_REG_SW_DELAY:  wb_dat_o <= {16'h0000, switch_delay};
               `PMS_REG_DEC_DELAY: wb_dat_o <= {16'h0000, decrement_delay};
               `PMS_REG_PID_DELAY: wb_dat_o <= {16'h0000, pid_stage_delay};
               `PMS_REG_FREQ:      wb_dat_o <= {stage_down_frequency, stage_up_frequency};
               `PMS_REG_DI_SEL_A:  wb_dat_o <= multifunction_input_select[31:0];
               `PMS_REG_DI_SEL_B:  wb_dat_o <= {16'h0000, multifunction_input_select[47:32]};
               `PMS_REG_STATUS:    wb_dat_o <= {5'h00, cur, 5'h00, state,
                                                mains_connect_o, drive_connect_o};
               `PMS_REG_TERM_A:    wb_dat_o <= term_codes[31:0];
               `PMS_REG_TERM_B:    wb_dat_o <= term_codes[63:32];
               default:            wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // pms_sequencer

// ==== logic/pms_timebase_unused_guard.v ====
// no logic here

// ==== tb/pms_seq_chk.sv ====
// port checker for the pump motor staging sequencer
`timescale 1ns/1ps
module pms_seq_chk (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire [15:0] out_freq_i,
   input wire        stop_cmd_i,
   input wire [5:0]  multifunction_input_i,
   input wire [7:0]  drive_connect_o,
   input wire [7:0]  mains_connect_o
);
   reg  [2:0] mode_q;
   wire       take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [7:0] all_w  = drive_connect_o | mains_connect_o;

   // mode field shadow
   always @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= 3'h0;
      end else if (take_w && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
         mode_q <= wb_dat_i[2:0];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_timing_a: assert property (take_w |=> wb_ack_o)
      else $error("bus ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   unmap_read_a: assert property (take_w && !wb_we_i && wb_adr_i > 8'h28 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   relay_excl_a: assert property ((drive_connect_o & mains_connect_o) == 8'h00)
      else $error("motor on drive and mains at once");
   one_drive_a: assert property ($onehot0(drive_connect_o))
      else $error("more than one motor on drive");
   reset_quiet_a: assert property ($fell(rst_i) |-> all_w == 8'h00)
      else $error("relays active after reset");
   stop_clear_a: assert property (stop_cmd_i [*5] |=> all_w == 8'h00)
      else $error("relays active under stop");
   mode_idle_a: assert property ((mode_q == 3'h0) [*4] |-> all_w == 8'h00)
      else $error("relays active in mode zero");
   circ_limit_a: assert property (mode_q == 3'h2 |-> $countones(all_w) <= 4)
      else $error("too many motors staged");
endmodule // pms_seq_chk

bind pms_sequencer pms_seq_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_freq_i(out_freq_i),
   .stop_cmd_i(stop_cmd_i), .multifunction_input_i(multifunction_input_i),
   .drive_connect_o(drive_connect_o), .mains_connect_o(mains_connect_o));

// ==== tb/pms_relay_model.sv ====
// contactor bank model behind the motor relay outputs
`timescale 1ns/1ps
module pms_relay_model #(
   parameter CLOSE_CYC = 4
) (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire [7:0] drive_coil_i,
   input  wire [7:0] mains_coil_i,
   output reg  [7:0] on_drive_o,
   output reg  [7:0] on_mains_o,
   output reg        short_o
);
   integer k;
   integer held_d [0:7];
   integer held_m [0:7];

   // contacts close after the coil is held, open at once
   always @(posedge clk_i) begin
      for (k = 0; k < 8; k = k + 1) begin
         held_d[k] <= (drive_coil_i[k] && !rst_i) ? held_d[k] + 1 : 0;
         held_m[k] <= (mains_coil_i[k] && !rst_i) ? held_m[k] + 1 : 0;
         on_drive_o[k] <= drive_coil_i[k] && !rst_i && held_d[k] >= CLOSE_CYC;
         on_mains_o[k] <= mains_coil_i[k] && !rst_i && held_m[k] >= CLOSE_CYC;
      end
      // drive output tied to mains on one motor
      if (rst_i) begin
         short_o <= 1'b0;
      end else if (|(on_drive_o & on_mains_o)) begin
         short_o <= 1'b1;
      end
   end
endmodule // pms_relay_model

// ==== tb/testbench.sv ====
// self-checking bench for the pump motor staging sequencer
`timescale 1ns/1ps
`include "pms_consts.vh"
module testbench;
   localparam TENTH = 10;
   localparam LIMIT = 40000;
   reg         clk_i;
   reg         rst_i;
   reg         wb_cyc;
   reg         wb_stb;
   reg         wb_we;
   reg  [7:0]  wb_adr;
   reg  [3:0]  wb_sel;
   reg  [31:0] wb_wdat;
   reg  [15:0] out_freq;
   reg         stop_cmd;
   reg  [5:0]  mf_in;
   reg  [31:0] rd;
   wire [31:0] wb_rdat;
   wire        wb_ack;
   wire [7:0]  drive_con;
   wire [7:0]  mains_con;
   wire [7:0]  on_drive;
   wire        short_seen;
   integer     fail_count;
   integer     tests_run;
   integer     cycles;

   pms_sequencer #(.TENTH_CYCLES(TENTH)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .out_freq_i(out_freq), .stop_cmd_i(stop_cmd),
      .multifunction_input_i(mf_in), .drive_connect_o(drive_con), .mains_connect_o(mains_con));

   pms_relay_model relays (
      .clk_i(clk_i), .rst_i(rst_i), .drive_coil_i(drive_con), .mains_coil_i(mains_con),
      .on_drive_o(on_drive), .on_mains_o(), .short_o(short_seen));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == LIMIT) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t ns: run timed out", $time);
         give_verdict;
      end
   end

   task check32(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t ns: word %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wait_rel(input [7:0] d, input [7:0] m, input integer max);
      integer n;
      begin
         n = 0;
         @(negedge clk_i);
         while ((drive_con !== d || mains_con !== m) && n < max) begin
            @(negedge clk_i);
            n = n + 1;
         end
         tests_run = tests_run + 1;
         if (drive_con !== d || mains_con !== m) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t ns: relays %h/%h expected %h/%h",
                     $time, drive_con, mains_con, d, m);
         end
      end
   endtask

   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         wb_cyc  <= 1'b1;
         wb_stb  <= 1'b1;
         wb_we   <= w;
         wb_adr  <= a;
         wb_wdat <= d;
         n = 0;
         @(posedge clk_i);
         while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (wb_ack !== 1'b1) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t ns: no bus ack", $time);
         end
         rd = wb_rdat;
         wb_cyc <= 1'b0;
         wb_stb <= 1'b0;
         wb_we  <= 1'b0;
      end
   endtask

   task pins(input [5:0] m, input s, input [15:0] f);
      begin
         @(posedge clk_i);
         mf_in    <= m;
         stop_cmd <= s;
         out_freq <= f;
      end
   endtask

   task test_reset;
      begin
         wb(1'b0, `PMS_REG_CTRL, 32'h0);
         check32(rd, 32'h0000_0010);
         wb(1'b0, `PMS_REG_SW_DELAY, 32'h0);
         check32(rd, 32'h0000_000A);
         wb(1'b0, `PMS_REG_FREQ, 32'h0);
         check32(rd, 32'h0000_1770);
         wait_rel(8'h00, 8'h00, 1);
         $display("test_reset done");
      end
   endtask

   task test_outmap;
      integer c;
      integer k;
      reg [63:0] exp;
      begin
         for (c = 1; c <= 8; c = c + 1) begin
            wb(1'b1, `PMS_REG_CTRL, c << 4);
            exp = 64'h0;
            for (k = 0; k < c; k = k + 1) exp[8*k +: 8] = 8'h37 + k;
            wb(1'b0, `PMS_REG_TERM_A, 32'h0);
            check32(rd, exp[31:0]);
            wb(1'b0, `PMS_REG_TERM_B, 32'h0);
            check32(rd, exp[63:32]);
         end
         wb(1'b1, `PMS_REG_CTRL, 32'h0000_0090);
         wb(1'b0, `PMS_REG_CTRL, 32'h0);
         check32(rd, 32'h0000_0080);
         wb(1'b1, `PMS_REG_CTRL, 32'h0000_0000);
         wb(1'b0, `PMS_REG_CTRL, 32'h0);
         check32(rd, 32'h0000_0080);
         wb(1'b0, 8'h30, 32'h0);
         check32(rd, 32'h0);
         $display("test_outmap done");
      end
   endtask

   task test_rotation;
      integer gap;
      begin
         wb(1'b1, `PMS_REG_SW_DELAY, 32'h2);
         wb(1'b1, `PMS_REG_RUN_TIME, 32'd65501);
         wb(1'b0, `PMS_REG_RUN_TIME, 32'h0);
         check32(rd, 32'h0);
         wb(1'b1, `PMS_REG_RUN_TIME, 32'd65500);
         wb(1'b0, `PMS_REG_RUN_TIME, 32'h0);
         check32(rd, 32'd65500);
         wb(1'b1, `PMS_REG_RUN_TIME, 32'h1);
         wb(1'b1, `PMS_REG_CTRL, 32'h0000_0031);
         wait_rel(8'h01, 8'h00, 8);
         wait_rel(8'h00, 8'h00, 6100);
         gap = 0;
         while (drive_con === 8'h00 && gap < 100) begin
            @(negedge clk_i);
            gap = gap + 1;
         end
         check32((gap >= TENTH && gap <= 3 * TENTH) ? 32'h1 : 32'h0, 32'h1);
         wait_rel(8'h02, 8'h00, 1);
         wb(1'b1, `PMS_REG_RUN_TIME, 32'h0);
         repeat (6200) @(negedge clk_i);
         wait_rel(8'h02, 8'h00, 1);
         $display("test_rotation done");
      end
   endtask

   task test_disable;
      begin
         wb(1'b1, `PMS_REG_DI_SEL_A, 32'h0000_3E3C);
         pins(6'h02, 1'b0, 16'h0);
         wait_rel(8'h00, 8'h00, 8);
         pins(6'h04, 1'b0, 16'h0);
         wait_rel(8'h02, 8'h00, 8);
         pins(6'h01, 1'b0, 16'h0);
         wait_rel(8'h00, 8'h00, 8);
         pins(6'h00, 1'b0, 16'h0);
         wait_rel(8'h02, 8'h00, 8);
         $display("test_disable done");
      end
   endtask

   task test_stop;
      begin
         pins(6'h00, 1'b1, 16'h0);
         wait_rel(8'h00, 8'h00, 8);
         pins(6'h00, 1'b0, 16'h0);
         wait_rel(8'h01, 8'h00, 8);
         wb(1'b1, `PMS_REG_CTRL, 32'h0000_0030);
         wait_rel(8'h00, 8'h00, 5);
         wb(1'b0, `PMS_REG_STATUS, 32'h0);
         check32(rd, 32'h0);
         $display("test_stop done");
      end
   endtask

   task test_staging;
      begin
         wb(1'b1, `PMS_REG_PID_DELAY, 32'h1);
         wb(1'b1, `PMS_REG_SW_DELAY, 32'h1);
         wb(1'b1, `PMS_REG_DEC_DELAY, 32'h1);
         wb(1'b1, `PMS_REG_FREQ, 32'h03E8_1770);
         pins(6'h00, 1'b0, 16'h1770);
         wb(1'b1, `PMS_REG_CTRL, 32'h0000_0082);
         wait_rel(8'h01, 8'h00, 8);
         wait_rel(8'h00, 8'h01, 100);
         wait_rel(8'h02, 8'h01, 100);
         wait_rel(8'h08, 8'h07, 600);
         repeat (300) @(negedge clk_i);
         wait_rel(8'h08, 8'h07, 1);
         check32({24'h0, on_drive}, 32'h0000_0008);
         pins(6'h00, 1'b0, 16'd500);
         wait_rel(8'h08, 8'h03, 100);
         wait_rel(8'h08, 8'h01, 100);
         wait_rel(8'h08, 8'h00, 100);
         check32({31'h0, short_seen}, 32'h0);
         $display("test_staging done");
      end
   endtask

   initial begin
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_wdat = 32'h0;
      out_freq = 16'h0;
      stop_cmd = 1'b0;
      mf_in = 6'h00;
      fail_count = 0;
      tests_run = 0;
      cycles = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset;
      test_outmap;
      test_rotation;
      test_disable;
      test_stop;
      test_staging;
      give_verdict;
   end
endmodule // testbench
